// ---- adcop_pkg.sv ----
// Shared constants and carrier types of the converter result output port.
package adcop_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int RESULT_W = 16;
	localparam int BIT_CNT_W = 5;
	localparam int PHASE_W = 6;
	localparam logic [4:0] RESULT_BITS = 5'h10;

	// Least serial clock period per divider code, in ns.
	localparam int SCLK_MIN_NS_00 = 30;
	localparam int SCLK_MIN_NS_01 = 60;
	localparam int SCLK_MIN_NS_10 = 120;
	localparam int SCLK_MIN_NS_11 = 240;
	localparam logic [PHASE_W-1:0] SCLK_CYC_00 = PHASE_W'((SCLK_MIN_NS_00 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [PHASE_W-1:0] SCLK_CYC_01 = PHASE_W'((SCLK_MIN_NS_01 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [PHASE_W-1:0] SCLK_CYC_10 = PHASE_W'((SCLK_MIN_NS_10 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [PHASE_W-1:0] SCLK_CYC_11 = PHASE_W'((SCLK_MIN_NS_11 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// Register map, byte addresses.
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [11:0] REG_RESULT = 12'h008;
	localparam int CTRL_ENABLE_BIT = 0;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

	// Data bus pin positions shared with serial controls.
	localparam int PIN_DIV_LO = 2;
	localparam int PIN_DIV_HI = 3;
	localparam int PIN_CLK_SRC = 4;
	localparam int PIN_SYNC_POL = 5;
	localparam int PIN_EDGE = 6;
	localparam int PIN_RDC = 7;
	localparam logic [15:0] OE_ALL = 16'hFFFF;
	localparam logic [15:0] OE_SERIAL = 16'h0003;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SHIFT = 3'b010,
		ST_FINISH = 3'b100
	} adcop_state_t;

	typedef struct packed {
		logic byte_order_select;
		logic output_coding_select;
		logic serial_parallel_select;
		logic cs_n;
		logic serial_data_clock;
		logic [7:2] d;
	} adcop_pins_t;

	typedef struct packed {
		logic [15:0] out;
		logic [15:0] oe;
	} adcop_bus_t;

	typedef struct packed {
		logic data_clock;
		logic data_clock_oe;
		logic result_out;
		logic result_oe;
		logic frame_sync;
		logic frame_sync_oe;
	} adcop_serial_t;
endpackage : adcop_pkg

// ---- adcop_buffer.sv ----
// Two-entry valid/ready buffer in the result path.
`timescale 1ns/1ps
module adcop_buffer #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// Drain side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	import adcop_pkg::*;
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PTR_W:0] FULL_COUNT = (PTR_W + 1)'(DEPTH);
	localparam logic [PTR_W-1:0] LAST_SLOT = PTR_W'(DEPTH - 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PTR_W-1:0] wr;
		logic [PTR_W-1:0] rd;
		logic [PTR_W:0] count;
	} adcop_buf_state_t;

	adcop_buf_state_t r;
	adcop_buf_state_t next_r;
	logic push;
	logic pop;

	function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
		bump = (p == LAST_SLOT) ? '0 : p + 1'b1;
	endfunction : bump

	assign in_ready = (r.count != FULL_COUNT);
	assign out_valid = (r.count != '0);
	assign out_data = r.mem[r.rd];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		next_r = r;
		if (push) begin
			next_r.mem[r.wr] = in_data;
			next_r.wr = bump(r.wr);
		end
		if (pop) begin
			next_r.rd = bump(r.rd);
		end
		next_r.count = r.count + (PTR_W + 1)'(push) - (PTR_W + 1)'(pop);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
endmodule : adcop_buffer

// ---- adcop_port.sv ----
// Result output port: parallel bus, serial master and serial slave, with an APB register slave.
`timescale 1ns/1ps
// Contract
// - Byte order select high puts low byte on upper half, else reversed.
// - Output coding select high presents straight binary unchanged.
// - Output coding select low inverts result MSB, giving twos complement.
// - Serial/parallel select low drives the full parallel data bus.
// - Serial/parallel select high uses shared pins for serial, rest high impedance.
// - Data bits 0 and 1 are always outputs.
// - In parallel mode bits 2, 3 and 4 drive result bits.
// - Serial master read-after-convert uses bits 2 and 3 as clock divider.
// - Other serial modes keep divider pins high impedance.
// - Clock source low: master, internal serial clock driven out.
// - Clock source high: slave, shift on external clock gated by chip select.
// - Divider code gives least clock period 30, 60, 120 or 240 ns.
// - Read-during-convert high sends previous result in master mode; low, or slave mode, sends the current one.
// - Frame sync polarity low gives active high sync, high active low.
// - Edge select low acts on rising edges, high on falling edges.
module adcop_port (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Results from the converter core
	input wire logic result_valid,
	input wire logic [adcop_pkg::RESULT_W-1:0] result_data,
	output logic result_ready,
	// Select pins
	input wire logic byte_order_select,
	input wire logic output_coding_select,
	input wire logic serial_parallel_select,
	input wire logic cs_n,
	// Data bus pins
	input wire logic [15:0] d_in,
	output adcop_pkg::adcop_bus_t d_bus,
	// Serial pins
	input wire logic serial_data_clock_in,
	output adcop_pkg::adcop_serial_t serial
);
	import adcop_pkg::*;

	typedef struct packed {
		adcop_pins_t s1;
		adcop_pins_t s2;
		logic clk_prev;
		adcop_state_t st;
		logic [RESULT_W-1:0] shift;
		logic [RESULT_W-1:0] held;
		logic [RESULT_W-1:0] par_word;
		logic [BIT_CNT_W-1:0] bits;
		logic [PHASE_W-1:0] phase;
		logic clk_raw;
		logic [31:0] ctrl;
		logic [31:0] rdata;
		logic err;
	} adcop_core_t;

	adcop_core_t r;
	adcop_core_t next_r;
	adcop_pins_t pins_raw;
	logic buf_valid;
	logic [RESULT_W-1:0] buf_data;
	logic buf_pop;
	logic enable;
	logic serial_mode;
	logic slave;
	logic read_during_convert_select;
	logic cs_act;
	logic ext_edge;
	logic [PHASE_W-1:0] period;
	logic [PHASE_W-1:0] half;
	logic [RESULT_W-1:0] coded;

	function automatic logic [RESULT_W-1:0] apply_coding(input logic [RESULT_W-1:0] w, input logic straight);
		apply_coding = w;
		apply_coding[RESULT_W-1] = straight ? w[RESULT_W-1] : ~w[RESULT_W-1];
	endfunction : apply_coding

	function automatic logic [PHASE_W-1:0] sclk_period(input logic [1:0] code);
		case (code)
			2'b00: sclk_period = SCLK_CYC_00;
			2'b01: sclk_period = SCLK_CYC_01;
			2'b10: sclk_period = SCLK_CYC_10;
			default: sclk_period = SCLK_CYC_11;
		endcase
	endfunction : sclk_period

	////////////////////////////////////////////////////////////////////////////////
	adcop_buffer #(
		.WIDTH(RESULT_W),
		.DEPTH(2)
	) u_buffer (
		.pclk(pclk),
		.presetn(presetn),
		.in_valid(result_valid),
		.in_data(result_data),
		.in_ready(result_ready),
		.out_valid(buf_valid),
		.out_data(buf_data),
		.out_ready(buf_pop)
	);

	////////////////////////////////////////////////////////////////////////////////
	assign pins_raw = '{byte_order_select, output_coding_select, serial_parallel_select, cs_n,
		serial_data_clock_in, d_in[7:2]};
	assign enable = r.ctrl[CTRL_ENABLE_BIT];
	assign serial_mode = r.s2.serial_parallel_select;
	assign slave = r.s2.d[PIN_CLK_SRC];
	assign read_during_convert_select = r.s2.d[PIN_RDC];
	assign cs_act = !r.s2.cs_n && enable;
	// The external clock is sampled, so the host clock must stay slower than about a third of pclk.
	assign ext_edge = r.s2.d[PIN_EDGE] ? (r.clk_prev && !r.s2.serial_data_clock)
		: (!r.clk_prev && r.s2.serial_data_clock);
	assign period = sclk_period((serial_mode && !slave && !read_during_convert_select) ? {r.s2.d[PIN_DIV_HI], r.s2.d[PIN_DIV_LO]} : 2'b00);
	assign half = (period + 1'b1) >> 1;
	assign coded = apply_coding(buf_data, r.s2.output_coding_select);
	assign buf_pop = buf_valid && (!serial_mode || (r.st == ST_IDLE && cs_act));

	always_comb begin
		next_r = r;
		next_r.s1 = pins_raw;
		next_r.s2 = r.s1;
		next_r.clk_prev = r.s2.serial_data_clock;
		if (!serial_mode) begin
			next_r.st = ST_IDLE;
			next_r.clk_raw = 1'b0;
			if (buf_pop) begin
				next_r.par_word = coded;
			end
		end else begin
			case (r.st)
				ST_IDLE: begin
					next_r.clk_raw = 1'b0;
					if (buf_pop) begin
						next_r.shift = read_during_convert_select && !slave ? r.held : coded;
						next_r.held = coded;
						next_r.par_word = coded;
						next_r.bits = '0;
						next_r.phase = '0;
						next_r.st = ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					if (!cs_act) begin
						next_r.st = ST_IDLE;
						next_r.clk_raw = 1'b0;
					end else if (slave) begin
						if (ext_edge) begin
							next_r.shift = {r.shift[RESULT_W-2:0], 1'b0};
							next_r.bits = r.bits + 1'b1;
							if (r.bits + 1'b1 == RESULT_BITS) begin
								next_r.st = ST_FINISH;
							end
						end
					end else begin
						next_r.phase = (r.phase + 1'b1 == period) ? '0 : r.phase + 1'b1;
						if (r.phase == '0) begin
							next_r.clk_raw = 1'b1;
						end
						if (r.phase == half) begin
							next_r.clk_raw = 1'b0;
							next_r.shift = {r.shift[RESULT_W-2:0], 1'b0};
							next_r.bits = r.bits + 1'b1;
							if (r.bits + 1'b1 == RESULT_BITS) begin
								next_r.st = ST_FINISH;
							end
						end
					end
				end
				ST_FINISH: begin
					next_r.clk_raw = 1'b0;
					// One word per chip select: wait for release so a buffered word is not started unseen.
					if (!cs_act) begin
						next_r.st = ST_IDLE;
					end
				end
				default: begin
					next_r.st = ST_IDLE;
				end
			endcase
		end

		// APB: read data is prepared in the setup cycle so the access phase needs no wait state.
		if (psel && !penable) begin
			next_r.err = 1'b0;
			case (paddr)
				REG_CTRL: next_r.rdata = r.ctrl;
				REG_STATUS: next_r.rdata = {20'h00000, r.st, buf_valid, read_during_convert_select, slave, serial_mode, r.bits};
				REG_RESULT: next_r.rdata = {16'h0000, r.par_word};
				default: begin
					next_r.rdata = 32'h0000_0000;
					next_r.err = 1'b1;
				end
			endcase
		end
		if (psel && penable && pwrite && paddr == REG_CTRL) begin
			next_r.ctrl = pwdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '{default: '0, st: ST_IDLE, ctrl: CTRL_RESET, s1: '{default: '1}, s2: '{default: '1}};
		end else begin
			r <= next_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign pready = 1'b1;
	assign pslverr = psel && penable && r.err;
	assign prdata = r.rdata;

	always_comb begin
		d_bus.out = r.s2.byte_order_select ? {r.par_word[7:0], r.par_word[15:8]} : r.par_word;
		if (!enable) begin
			d_bus.out = '0;
		end
		if (!serial_mode) begin
			d_bus.oe = enable ? OE_ALL : OE_SERIAL;
		end else begin
			d_bus.oe = OE_SERIAL;
			d_bus.out = '0;
		end
		serial.data_clock = r.clk_raw ^ r.s2.d[PIN_EDGE];
		serial.data_clock_oe = serial_mode && !slave && cs_act;
		serial.result_out = r.shift[RESULT_W-1];
		serial.result_oe = serial_mode && cs_act;
		serial.frame_sync = (r.st == ST_SHIFT) ^ r.s2.d[PIN_SYNC_POL];
		serial.frame_sync_oe = serial_mode && !slave && cs_act;
	end
endmodule : adcop_port

// ---- adcop_port_checker.sv ----
// Checker of pin drive relations of the result output port.
`timescale 1ns/1ps
module adcop_port_checker (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Watched ports
	input wire logic psel,
	input wire logic penable,
	input wire logic pslverr,
	input wire logic serial_parallel_select,
	input wire logic [15:0] d_in,
	input wire adcop_pkg::adcop_bus_t d_bus,
	input wire adcop_pkg::adcop_serial_t serial
);
	import adcop_pkg::*;
	logic [2:0] quiet;
	logic [6:0] last;
	logic calm;
	// Selects pass sync flops, so select-dependent pin relations are judged only after the selects stay quiet.
	assign calm = (quiet > 3'h4) && (last == {serial_parallel_select, d_in[7:2]});
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			quiet <= 3'h0;
			last <= 7'h00;
		end else begin
			last <= {serial_parallel_select, d_in[7:2]};
			quiet <= (last != {serial_parallel_select, d_in[7:2]}) ? 3'h0 : quiet + 3'(quiet != 3'h7);
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_low_pins; d_bus.oe[1:0] == 2'h3; endproperty
	a_low_pins: assert property (p_low_pins) else $error("low data pins released");
	property p_ser_hiz; calm && serial_parallel_select |-> d_bus.oe[15:4] == 12'h000; endproperty
	a_ser_hiz: assert property (p_ser_hiz) else $error("serial mode drives data pins");
	property p_par_drive; calm && !serial_parallel_select |=> d_bus.oe == 16'hFFFF; endproperty
	a_par_drive: assert property (p_par_drive) else $error("parallel bus not driven");
	property p_div_hiz; calm && serial_parallel_select && (d_in[4] || d_in[7]) |-> d_bus.oe[3:2] == 2'h0; endproperty
	a_div_hiz: assert property (p_div_hiz) else $error("divider pins driven");
	property p_slave_clk; calm && serial_parallel_select && d_in[4] |-> !serial.data_clock_oe; endproperty
	a_slave_clk: assert property (p_slave_clk) else $error("slave drives clock");
	property p_master_pair; serial.data_clock_oe |-> serial.result_oe; endproperty
	a_master_pair: assert property (p_master_pair) else $error("clock without data");
	property p_sync_oe; serial.frame_sync_oe == serial.data_clock_oe; endproperty
	a_sync_oe: assert property (p_sync_oe) else $error("sync drive mismatch");
	property p_err_phase; pslverr |-> psel && penable; endproperty
	a_err_phase: assert property (p_err_phase) else $error("error outside access");
endmodule : adcop_port_checker
bind adcop_port adcop_port_checker adcop_port_checker_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pslverr(pslverr), .serial_parallel_select(serial_parallel_select), .d_in(d_in),
	.d_bus(d_bus), .serial(serial));

// ---- adcop_host_model.sv ----
// Host model that reads results over the serial port.
`timescale 1ns/1ps
module adcop_host_model (
	// Clock
	input wire logic pclk,
	// Serial pins
	input wire adcop_pkg::adcop_serial_t serial,
	output logic cs_n,
	output logic ext_clk
);
	import adcop_pkg::*;
	initial begin
		cs_n = 1'b1;
		ext_clk = 1'b0;
	end
	// The clock runs only while selected; eight cycles a period keeps it under a third of pclk.
	task automatic read_slave(output logic [15:0] word);
		cs_n <= 1'b0;
		repeat (6) @(posedge pclk);
		for (int i = 15; i >= 0; i--) begin
			word[i] = serial.result_out;
			ext_clk <= 1'b1;
			repeat (4) @(posedge pclk);
			ext_clk <= 1'b0;
			repeat (4) @(posedge pclk);
		end
		cs_n <= 1'b1;
		@(posedge pclk);
	endtask : read_slave
	task automatic read_master(output logic [15:0] word, output int period, output logic sync);
		int i = 15;
		int t = 0;
		int last = 0;
		logic prev = 1'b0;
		period = 0;
		cs_n <= 1'b0;
		while (i >= 0 && t < 2000) begin
			@(posedge pclk);
			t++;
			if (serial.data_clock && !prev) begin
				if (i == 15) sync = serial.frame_sync;
				if (i == 14) period = t - last;
				last = t;
				word[i] = serial.result_out;
				i--;
			end
			prev = serial.data_clock;
		end
		cs_n <= 1'b1;
		repeat (4) @(posedge pclk);
	endtask : read_master
endmodule : adcop_host_model

// ---- adcop_port_tb.sv ----
// Self-checking testbench of the result output port.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module adcop_port_tb;
	import adcop_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic result_valid = 1'b0, result_ready, cs_n, ext_clk;
	logic [15:0] result_data = 16'h0000, d_in = 16'h0000;
	logic byte_order_select = 1'b0, output_coding_select = 1'b1, serial_parallel_select = 1'b0;
	adcop_bus_t d_bus;
	adcop_serial_t serial;
	int err_count = 0, checks = 0, cyc = 0;
	adcop_port adcop_port_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.result_valid(result_valid), .result_data(result_data), .result_ready(result_ready),
		.byte_order_select(byte_order_select), .output_coding_select(output_coding_select),
		.serial_parallel_select(serial_parallel_select), .cs_n(cs_n), .d_in(d_in), .d_bus(d_bus),
		.serial_data_clock_in(ext_clk), .serial(serial));
	adcop_host_model adcop_host_model_inst (.pclk(pclk), .serial(serial), .cs_n(cs_n), .ext_clk(ext_clk));
	initial forever #5 pclk = ~pclk;
	////////////////////////////////////////////////////////////////
	function automatic logic [15:0] coded(logic [15:0] w, logic oc);
		return oc ? w : {~w[15], w[14:0]};
	endfunction : coded
	task automatic print_verdict();
		if (err_count == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : print_verdict
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic er);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic push(input logic [15:0] w, output logic ok);
		@(posedge pclk);
		result_valid <= 1'b1;
		result_data <= w;
		@(posedge pclk);
		ok = result_ready;
		result_valid <= 1'b0;
	endtask : push
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			print_verdict();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] rd;
		logic er, ok, sy;
		logic [15:0] w;
		int per;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, REG_CTRL, 32'h0, rd, er);
		`CHK("ctrl", CTRL_RESET, rd)
		apb(1'b1, REG_CTRL, CTRL_RESET, rd, er);
		apb(1'b0, 12'h0FC, 32'h0, rd, er);
		`CHK("unmapped", 1'b1, er)
		for (int k = 0; k < 4; k++) begin
			byte_order_select <= k[0];
			output_coding_select <= k[1];
			repeat (4) @(posedge pclk);
			push(16'h8135 + 16'(k), ok);
			repeat (4) @(posedge pclk);
			w = coded(16'h8135 + 16'(k), k[1]);
			`CHK("par out", k[0] ? {w[7:0], w[15:8]} : w, d_bus.out)
			`CHK("par oe", 16'hFFFF, d_bus.oe)
		end
		output_coding_select <= 1'b0;
		serial_parallel_select <= 1'b1;
		d_in <= 16'h0010;
		repeat (6) @(posedge pclk);
		push(16'h1234, ok);
		push(16'hC001, ok);
		push(16'h7777, ok);
		`CHK("full", 1'b0, ok)
		`CHK("ser oe", OE_SERIAL, d_bus.oe)
		adcop_host_model_inst.read_slave(w);
		`CHK("slave 1", coded(16'h1234, 1'b0), w)
		adcop_host_model_inst.read_slave(w);
		`CHK("slave 2", coded(16'hC001, 1'b0), w)
		for (int k = 0; k < 4; k++) begin
			d_in <= {10'h000, k[0], 1'b0, k[1:0], 2'h0};
			repeat (6) @(posedge pclk);
			push(16'hA5C3 ^ 16'(k), ok);
			adcop_host_model_inst.read_master(w, per, sy);
			`CHK("master", coded(16'hA5C3 ^ 16'(k), 1'b0), w)
			`CHK("period", (SCLK_MIN_NS_00 << k) / CLK_PERIOD_NS, per)
			`CHK("sync", !k[0], sy)
		end
		d_in <= 16'h008C;
		repeat (6) @(posedge pclk);
		push(16'h5A5A, ok);
		adcop_host_model_inst.read_master(w, per, sy);
		`CHK("rdc prev", coded(16'hA5C0, 1'b0), w)
		`CHK("rdc period", SCLK_MIN_NS_00 / CLK_PERIOD_NS, per)
		print_verdict();
	end
endmodule : adcop_port_tb
